/* verilog/epsb_pkg.sv */
/*
  Shared constants and carrier types for the endpoint sideband block:
  register offsets, field positions, reset values and the packed structs
  that group the register port, the error inputs and the config outputs.
  Assumes a single 40 MHz clock and user logic on that same clock.
*/
// Contract
// - CRC check flag stays high while AER and CRC exist and checking is enabled.
// - Completion timeout pulse sends a non-fatal message and sets its AER status bit.
// - Non-posted completer abort sends a non-fatal message and sets its AER status bit.
// - Posted completer abort sends a non-fatal message and sets its AER status bit.
// - Unexpected completion sends a non-fatal message and sets its AER status bit.
// - Device status bit 5 follows the non-posted pending input.
// - Bus, device and function numbers from configuration writes are driven out.
// - Six command register bits are driven out, bit 5 interrupt disable.
// - Fifteen low device control bits are driven out continuously.
// - Eight low link control bits are driven out continuously.
// - Falling legacy line sends an assert message and sets interrupt status.
// - Rising legacy line sends a deassert message and clears interrupt status.
// - Interrupt disable blocks the messages but interrupt status still updates.
`default_nettype none

package epsb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_DEVCTL   = 8'h04;
  localparam logic [7:0] OFS_LNKCTL   = 8'h08;
  localparam logic [7:0] OFS_BDF      = 8'h0C;
  localparam logic [7:0] OFS_ECRC     = 8'h10;
  localparam logic [7:0] OFS_DEVSTAT  = 8'h14;
  localparam logic [7:0] OFS_AER_STAT = 8'h18;
  localparam logic [7:0] OFS_HDR0     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h34;

  // Field positions
  localparam int CMD_INT_DIS   = 5;
  localparam int CMD_SERR_EN   = 4;
  localparam int DEVCTL_NF_EN  = 1;
  localparam int BDF_BUS_LSB   = 8;
  localparam int BDF_DEV_LSB   = 3;
  localparam int ECRC_GEN_BIT  = 0;
  localparam int ECRC_CHK_BIT  = 1;
  localparam int DSTAT_INT_BIT = 3;
  localparam int DSTAT_NP_BIT  = 5;
  localparam int AER_CTO_BIT   = 14;
  localparam int AER_CA_BIT    = 15;
  localparam int AER_UC_BIT    = 16;
  localparam int AER_W         = 17;

  // Interrupt event bits
  localparam int EV_CTO   = 0;
  localparam int EV_NPCA  = 1;
  localparam int EV_PCA   = 2;
  localparam int EV_UC    = 3;
  localparam int EV_INTA  = 4;
  localparam int EV_INTD  = 5;
  localparam int EV_W     = 6;

  // Reset values
  localparam logic [5:0]  CMD_RST    = 6'h00;
  localparam logic [14:0] DEVCTL_RST = 15'h2810;
  localparam logic [7:0]  LNKCTL_RST = 8'h00;
  localparam logic [15:0] BDF_RST    = 16'h0000;
  localparam logic [1:0]  ECRC_RST   = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } epsb_reg_req_t;

  typedef struct packed {
    logic [127:0] hdr;
    logic         cmpln_tout;
    logic         nonposted_abort_in;
    logic         posted_abort;
    logic         unexp_cmpln;
    logic         nonposted_pending_in;
  } epsb_err_in_t;

  typedef struct packed {
    logic [7:0]  bus_num;
    logic [4:0]  dev_num;
    logic [2:0]  func_num;
    logic [5:0]  cmd;
    logic [14:0] dev_cntl;
    logic [7:0]  link_cntl;
  } epsb_cfg_out_t;

endpackage : epsb_pkg

`default_nettype wire

/* verilog/epsb_intx.sv */
/*
  Legacy interrupt edge tracker: turns edges of the active-low line into
  one-cycle assert and deassert message requests and keeps the interrupt
  status bit. Assumes the line comes from logic on the same clock.
*/
`default_nettype none

module epsb_intx (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Line and gating
  input  wire logic inta_n,
  input  wire logic int_disable,
  // Results
  output var  logic assert_msg,
  output var  logic deassert_msg,
  output var  logic int_status
);
  import epsb_pkg::*;

  typedef struct packed {
    logic prev_n;
    logic status;
    logic amsg;
    logic dmsg;
  } epsb_intx_st_t;

  epsb_intx_st_t st_r;
  epsb_intx_st_t st_nxt;
  logic          fall;
  logic          rise;

  // Edge detection against the last sampled level
  always_comb begin
    st_nxt        = st_r;
    fall          = st_r.prev_n & ~inta_n;
    rise          = ~st_r.prev_n & inta_n;
    st_nxt.prev_n = inta_n;
    st_nxt.amsg   = fall & ~int_disable;
    st_nxt.dmsg   = rise & ~int_disable;
    if (fall) begin
      st_nxt.status = 1'b1;
    end else if (rise) begin
      st_nxt.status = 1'b0;
    end
  end

  // Line idles high, so no edge is seen coming out of reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{prev_n: 1'b1, status: 1'b0, amsg: 1'b0, dmsg: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign assert_msg   = st_r.amsg;
  assign deassert_msg = st_r.dmsg;
  assign int_status   = st_r.status;

endmodule : epsb_intx

`default_nettype wire

/* verilog/epsb_top.sv */
/*
  Endpoint sideband: error indications to non-fatal messages and AER
  status with a header log, configuration values held for user logic,
  legacy interrupt messages, and a small interrupt controller.
  Assumes all user-side inputs are synchronous to REF_CLK and that a
  simple register port stands in for configuration writes.
*/
`default_nettype none

module epsb_top #(
  parameter bit AER_PRESENT  = 1'b1,
  parameter bit ECRC_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   SRST,
  // Register port
  input  wire epsb_pkg::epsb_reg_req_t REG_REQ,
  output var  logic [31:0]            REG_RDATA,
  // Error indications from user logic
  input  wire epsb_pkg::epsb_err_in_t  ERR_IN,
  // Legacy interrupt line
  input  wire logic                   INTA_N,
  // Configuration values to user logic
  output var  epsb_pkg::epsb_cfg_out_t CFG_OUT,
  output var  logic                   ECRC_GEN_ENB,
  output var  logic                   ECRC_CHK_ENB,
  // Message requests to the transaction layer
  output var  logic                   NONFATAL_MSG,
  output var  logic                   INTX_ASSERT_MSG,
  output var  logic                   INTX_DEASSERT_MSG,
  // Interrupt to local processor
  output var  logic                   IRQ
);
  import epsb_pkg::*;

  typedef struct packed {
    logic [5:0]        cmd;
    logic [14:0]       devctl;
    logic [7:0]        lnkctl;
    logic [15:0]       bdf;
    logic [1:0]        ecrc;
    logic              np_pend;
    logic [AER_W-1:0]  aer;
    logic              hdr_valid;
    logic [127:0]      hdr;
    logic [EV_W-1:0]   irq_stat;
    logic [EV_W-1:0]   irq_en;
    logic [31:0]       rdata;
    logic              nf_msg;
    logic              gen_enb;
    logic              chk_enb;
    logic              irq;
  } epsb_st_t;

  epsb_st_t        st_r;
  epsb_st_t        st_nxt;
  logic            amsg;
  logic            dmsg;
  logic            int_status;
  logic            hdr_err;
  logic            any_err;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irq_next;
  logic            ecrc_cap;

  // Register write decode, used for every writable offset
  function automatic logic wr_hit(input epsb_reg_req_t req, input logic [7:0] ofs);
    return req.wr && (req.addr == ofs);
  endfunction : wr_hit

  // Header log word select; word 0 holds the first header dword
  function automatic logic [31:0] hdr_word(input logic [127:0] h, input logic [1:0] idx);
    return h[127 - 32*idx -: 32];
  endfunction : hdr_word

  // Legacy interrupt edges and messages
  epsb_intx u_intx (
    .clk          (REF_CLK),
    .srst         (SRST),
    .inta_n       (INTA_N),
    .int_disable  (st_r.cmd[CMD_INT_DIS]),
    .assert_msg   (amsg),
    .deassert_msg (dmsg),
    .int_status   (int_status)
  );

  assign ecrc_cap = AER_PRESENT & ECRC_PRESENT;

  // Error event collection
  always_comb begin
    hdr_err = ERR_IN.nonposted_abort_in | ERR_IN.posted_abort | ERR_IN.unexp_cmpln;
    any_err = hdr_err | ERR_IN.cmpln_tout;
    events  = '0;
    events[EV_CTO]  = ERR_IN.cmpln_tout;
    events[EV_NPCA] = ERR_IN.nonposted_abort_in;
    events[EV_PCA]  = ERR_IN.posted_abort;
    events[EV_UC]   = ERR_IN.unexp_cmpln;
    events[EV_INTA] = amsg;
    events[EV_INTD] = dmsg;
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    irq_next = st_r.irq_stat;
    if (wr_hit(REG_REQ, OFS_IRQ_CLR)) begin
      irq_next = irq_next & ~REG_REQ.wdata[EV_W-1:0];
    end
    irq_next = irq_next | events;
  end

  // Next state of everything software and events touch
  always_comb begin
    st_nxt = st_r;

    // Configuration values captured from writes
    if (wr_hit(REG_REQ, OFS_CMD)) begin
      st_nxt.cmd = REG_REQ.wdata[5:0];
    end
    if (wr_hit(REG_REQ, OFS_DEVCTL)) begin
      st_nxt.devctl = REG_REQ.wdata[14:0];
    end
    if (wr_hit(REG_REQ, OFS_LNKCTL)) begin
      st_nxt.lnkctl = REG_REQ.wdata[7:0];
    end
    if (wr_hit(REG_REQ, OFS_BDF)) begin
      st_nxt.bdf = REG_REQ.wdata[15:0];
    end
    if (wr_hit(REG_REQ, OFS_ECRC)) begin
      st_nxt.ecrc = REG_REQ.wdata[1:0];
    end
    if (wr_hit(REG_REQ, OFS_IRQ_EN)) begin
      st_nxt.irq_en = REG_REQ.wdata[EV_W-1:0];
    end

    // Flags follow the enables only where both capabilities exist
    st_nxt.gen_enb = ecrc_cap & st_nxt.ecrc[ECRC_GEN_BIT];
    st_nxt.chk_enb = ecrc_cap & st_nxt.ecrc[ECRC_CHK_BIT];

    // Pending non-posted level mirrored into device status
    st_nxt.np_pend = ERR_IN.nonposted_pending_in;

    // AER status: write one to clear, a new error wins
    if (wr_hit(REG_REQ, OFS_AER_STAT)) begin
      st_nxt.aer = st_r.aer & ~REG_REQ.wdata[AER_W-1:0];
      if (REG_REQ.wdata[AER_CA_BIT] | REG_REQ.wdata[AER_UC_BIT]) begin
        st_nxt.hdr_valid = 1'b0;
      end
    end
    if (ERR_IN.cmpln_tout) begin
      st_nxt.aer[AER_CTO_BIT] = 1'b1;
    end
    if (ERR_IN.nonposted_abort_in) begin
      st_nxt.aer[AER_CA_BIT] = 1'b1;
    end
    if (ERR_IN.posted_abort) begin
      st_nxt.aer[AER_CA_BIT] = 1'b1;
    end
    if (ERR_IN.unexp_cmpln) begin
      st_nxt.aer[AER_UC_BIT] = 1'b1;
    end

    // Header sampled in the error's own cycle; first error is kept, a clear in the same cycle goes first and lets the new header in
    if (hdr_err && !st_nxt.hdr_valid) begin
      st_nxt.hdr       = ERR_IN.hdr;
      st_nxt.hdr_valid = 1'b1;
    end

    // One message per cycle with errors, when reporting is allowed
    st_nxt.nf_msg = any_err & (st_r.devctl[DEVCTL_NF_EN] | st_r.cmd[CMD_SERR_EN]);

    // Interrupt controller
    st_nxt.irq_stat = irq_next;
    st_nxt.irq      = |(irq_next & st_nxt.irq_en);

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        OFS_CMD:      st_nxt.rdata = {26'h0, st_r.cmd};
        OFS_DEVCTL:   st_nxt.rdata = {17'h0, st_r.devctl};
        OFS_LNKCTL:   st_nxt.rdata = {24'h0, st_r.lnkctl};
        OFS_BDF:      st_nxt.rdata = {16'h0, st_r.bdf};
        OFS_ECRC:     st_nxt.rdata = {30'h0, st_r.ecrc};
        OFS_DEVSTAT: begin
          st_nxt.rdata[DSTAT_NP_BIT]  = st_r.np_pend;
          st_nxt.rdata[DSTAT_INT_BIT] = int_status;
        end
        OFS_AER_STAT: st_nxt.rdata = {15'h0, st_r.aer};
        OFS_HDR0:          st_nxt.rdata = hdr_word(st_r.hdr, 2'd0);
        OFS_HDR0 + 8'h04:  st_nxt.rdata = hdr_word(st_r.hdr, 2'd1);
        OFS_HDR0 + 8'h08:  st_nxt.rdata = hdr_word(st_r.hdr, 2'd2);
        OFS_HDR0 + 8'h0C:  st_nxt.rdata = hdr_word(st_r.hdr, 2'd3);
        OFS_IRQ_STAT: st_nxt.rdata = {26'h0, st_r.irq_stat};
        OFS_IRQ_EN:   st_nxt.rdata = {26'h0, st_r.irq_en};
        default:      st_nxt.rdata = 32'h0000_0000;         // Unmapped and write-only read zero
      endcase
    end
  end

  // Single state register
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      st_r           <= '0;
      st_r.cmd       <= CMD_RST;
      st_r.devctl    <= DEVCTL_RST;
      st_r.lnkctl    <= LNKCTL_RST;
      st_r.bdf       <= BDF_RST;
      st_r.ecrc      <= ECRC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  always_comb begin
    CFG_OUT.bus_num   = st_r.bdf[15:BDF_BUS_LSB];
    CFG_OUT.dev_num   = st_r.bdf[7:BDF_DEV_LSB];
    CFG_OUT.func_num  = st_r.bdf[2:0];
    CFG_OUT.cmd       = st_r.cmd;
    CFG_OUT.dev_cntl  = st_r.devctl;
    CFG_OUT.link_cntl = st_r.lnkctl;
  end

  assign REG_RDATA         = st_r.rdata;
  assign ECRC_GEN_ENB      = st_r.gen_enb;          // depends on this flag
  assign ECRC_CHK_ENB      = st_r.chk_enb;
  assign NONFATAL_MSG      = st_r.nf_msg;
  assign INTX_ASSERT_MSG   = amsg;
  assign INTX_DEASSERT_MSG = dmsg;
  assign IRQ               = st_r.irq;

endmodule : epsb_top

`default_nettype wire

/* dv/epsb_checker.sv */
/*
  Port checker for epsb_top: message timing, gating and output holding.
  Assumes it is bound to epsb_top and sees only that module's ports.
*/
`default_nettype none

module epsb_checker (
  // Clock and reset
  input wire logic                    REF_CLK,
  input wire logic                    SRST,
  // Inputs of the block
  input wire epsb_pkg::epsb_reg_req_t REG_REQ,
  input wire epsb_pkg::epsb_err_in_t  ERR_IN,
  input wire logic                    INTA_N,
  // Outputs of the block
  input wire logic [31:0]             REG_RDATA,
  input wire epsb_pkg::epsb_cfg_out_t CFG_OUT,
  input wire logic                    ECRC_GEN_ENB,
  input wire logic                    ECRC_CHK_ENB,
  input wire logic                    NONFATAL_MSG,
  input wire logic                    INTX_ASSERT_MSG,
  input wire logic                    INTX_DEASSERT_MSG,
  input wire logic                    IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  import epsb_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // Error and gating terms, one cycle before the message
  wire logic err_any = ERR_IN.cmpln_tout | ERR_IN.nonposted_abort_in | ERR_IN.posted_abort | ERR_IN.unexp_cmpln;
  wire logic nf_on   = CFG_OUT.dev_cntl[DEVCTL_NF_EN] | CFG_OUT.cmd[CMD_SERR_EN];
  wire logic ecrc_wr = REG_REQ.wr && (REG_REQ.addr == OFS_ECRC);
  wire logic int_dis = CFG_OUT.cmd[CMD_INT_DIS];

  a_assert_msg: assert property ($fell(INTA_N) && !int_dis |=> INTX_ASSERT_MSG)
    else $error("assert message missing");
  a_deassert_msg: assert property ($rose(INTA_N) && !int_dis |=> INTX_DEASSERT_MSG)
    else $error("deassert message missing");
  a_disable_quiet: assert property (int_dis |=> !INTX_ASSERT_MSG && !INTX_DEASSERT_MSG)
    else $error("message sent while disabled");
  a_msg_single: assert property (INTX_ASSERT_MSG |=> !INTX_ASSERT_MSG && !INTX_DEASSERT_MSG)
    else $error("interrupt message too long");
  a_nf_sent: assert property (err_any && nf_on |=> NONFATAL_MSG)
    else $error("non-fatal message missing");
  a_nf_gated: assert property (!(err_any && nf_on) |=> !NONFATAL_MSG)
    else $error("unexpected non-fatal message");
  a_ecrc_hold: assert property (!$past(ecrc_wr) |-> $stable(ECRC_CHK_ENB) && $stable(ECRC_GEN_ENB))
    else $error("crc flag moved without write");
  a_cfg_hold: assert property (!$past(REG_REQ.wr) |-> $stable(CFG_OUT))
    else $error("config output moved without write");
  a_rdata_idle: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == 32'h0)
    else $error("read data outside read slot");
endmodule : epsb_checker

bind epsb_top epsb_checker u_chk (
  .REF_CLK(REF_CLK), .SRST(SRST), .REG_REQ(REG_REQ), .ERR_IN(ERR_IN), .INTA_N(INTA_N),
  .REG_RDATA(REG_RDATA), .CFG_OUT(CFG_OUT), .ECRC_GEN_ENB(ECRC_GEN_ENB), .ECRC_CHK_ENB(ECRC_CHK_ENB),
  .NONFATAL_MSG(NONFATAL_MSG), .INTX_ASSERT_MSG(INTX_ASSERT_MSG), .INTX_DEASSERT_MSG(INTX_DEASSERT_MSG), .IRQ(IRQ)
);

`default_nettype wire

/* dv/epsb_user_model.sv */
/*
  User application beside the endpoint: error pulses with header and
  the legacy interrupt line. Assumes the bench calls its tasks.
*/
`default_nettype none

module epsb_user_model (
  // Clock and config from the block
  input  wire logic                   clk,
  input  wire logic                   int_dis,
  input  wire logic                   crc_gen,
  // Drives to the block
  output var  epsb_pkg::epsb_err_in_t err,
  output wire logic                   inta_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import epsb_pkg::*;
  logic line_r = 1'b1;
  logic use_or = 1'b1;
  initial err = '0;
  // Line ORed with disable so a held request still deasserts
  assign inta_n = line_r | (use_or & int_dis);

  // One-cycle error pulse; header only valid in that cycle
  task automatic pulse(input logic [3:0] kinds, input logic [127:0] hdr);
    @(posedge clk);
    err.hdr <= {hdr[127:112], crc_gen, hdr[110:0]};
    {err.cmpln_tout, err.nonposted_abort_in, err.posted_abort, err.unexp_cmpln} <= kinds;
    @(posedge clk);
    {err.cmpln_tout, err.nonposted_abort_in, err.posted_abort, err.unexp_cmpln} <= 4'h0;
    err.hdr <= ~hdr;
  endtask : pulse

  // Pending level, changed right after an edge
  task automatic pending(input logic v);
    @(posedge clk);
    err.nonposted_pending_in <= v;
  endtask : pending

  // Move the line, then keep it for the spacing gap
  task automatic line(input logic v, input int gap);
    @(posedge clk);
    line_r <= v;
    repeat (gap) @(posedge clk);
  endtask : line
endmodule : epsb_user_model

`default_nettype wire

/* dv/epsb_top_test.sv */
/*
  Self-checking bench for epsb_top with the user model on its far side.
  Assumes the checker is bound in separately.
*/
`default_nettype none

module epsb_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import epsb_pkg::*;
  logic clk = 1'b0, srst = 1'b1, irq, nf, asm, dem, gen, chkf;
  epsb_reg_req_t req = '0;
  epsb_err_in_t  err;
  epsb_cfg_out_t cfg;
  logic [31:0]   rdata;
  wire logic     inta_n;
  int error_cnt = 0, tests_run = 0, cyc = 0, nf_n = 0, as_n = 0, de_n = 0;

  epsb_top dut (.REF_CLK(clk), .SRST(srst), .REG_REQ(req), .REG_RDATA(rdata), .ERR_IN(err), .INTA_N(inta_n),
    .CFG_OUT(cfg), .ECRC_GEN_ENB(gen), .ECRC_CHK_ENB(chkf), .NONFATAL_MSG(nf), .INTX_ASSERT_MSG(asm),
    .INTX_DEASSERT_MSG(dem), .IRQ(irq));
  epsb_user_model u (.clk(clk), .int_dis(cfg.cmd[CMD_INT_DIS]), .crc_gen(gen), .err(err), .inta_n(inta_n));

  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Message counters and hang guard
  always @(posedge clk) begin
    cyc++;
    nf_n += int'(nf === 1'b1);
    as_n += int'(asm === 1'b1);
    de_n += int'(dem === 1'b1);
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= {a, d, 2'b10};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data is only valid in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= {a, 32'h0, 2'b01};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk

  task automatic t_reset();
    rd_chk(OFS_CMD, 32'h0);
    rd_chk(OFS_DEVCTL, 32'(DEVCTL_RST));
    wr(OFS_DEVSTAT, 32'hFFFF_FFFF);
    rd_chk(OFS_DEVSTAT, 32'h0);
    rd_chk(8'hF0, 32'h0);
    $display("reset values done");
  endtask : t_reset

  task automatic t_cfg();
    wr(OFS_BDF, 32'hABCD);
    wr(OFS_CMD, 32'h15);
    wr(OFS_DEVCTL, 32'h5A5A);
    wr(OFS_LNKCTL, 32'hA5);
    #1 chk(32'({cfg.bus_num, cfg.dev_num, cfg.func_num}), 32'hABCD);
    chk(32'(cfg.cmd), 32'h15);
    chk(32'(cfg.dev_cntl), 32'h5A5A);
    chk(32'(cfg.link_cntl), 32'hA5);
    for (int i = 3; i >= 0; i--) begin
      wr(OFS_ECRC, 32'(i));
      #1 chk(32'({chkf, gen}), 32'(i));
    end
    wr(OFS_ECRC, 32'h1);
    $display("config outputs done");
  endtask : t_cfg

  task automatic t_err();
    logic [127:0] h;
    int aer[4] = '{14, 15, 15, 16};
    int n0;
    wr(OFS_IRQ_EN, 32'h3F);
    for (int k = 0; k < 4; k++) begin
      h = {28'h1234567, 4'(k), 96'h5};
      n0 = nf_n;
      u.pulse(4'b1000 >> k, h);
      @(posedge clk);
      #1 chk(32'(nf_n - n0), 32'h1);
      rd_chk(OFS_AER_STAT, 32'h1 << aer[k]);
      rd_chk(OFS_IRQ_STAT, 32'h1 << k);
      chk(32'(irq), 32'h1);
      if (k > 0) rd_chk(OFS_HDR0, h[127:96] | 32'h8000);
      wr(OFS_AER_STAT, 32'h1 << aer[k]);
      wr(OFS_IRQ_CLR, 32'h1 << k);
      rd_chk(OFS_IRQ_STAT, 32'h0);
      chk(32'(irq), 32'h0);
    end
    // All gates closed: status still sets, no message, no interrupt
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_CMD, 32'h0);
    wr(OFS_DEVCTL, 32'h0);
    n0 = nf_n;
    u.pulse(4'hF, h);
    repeat (2) @(posedge clk);
    #1 chk(32'(nf_n - n0), 32'h0);
    chk(32'(irq), 32'h0);
    rd_chk(OFS_AER_STAT, 32'h1C000);
    wr(OFS_AER_STAT, 32'h1C000);
    wr(OFS_IRQ_CLR, 32'hF);
    $display("error reporting done");
  endtask : t_err

  task automatic t_np();
    u.pending(1'b1);
    rd_chk(OFS_DEVSTAT, 32'h20);
    u.pending(1'b0);
    repeat (2) @(posedge clk);
    rd_chk(OFS_DEVSTAT, 32'h0);
    $display("pending status done");
  endtask : t_np

  task automatic t_intx();
    int a0 = as_n, d0 = de_n;
    wr(OFS_IRQ_EN, 32'h30);
    u.use_or <= 1'b0;
    u.line(1'b0, 2);
    rd_chk(OFS_DEVSTAT, 32'h08);
    chk(32'(as_n - a0), 32'h1);
    chk(32'(irq), 32'h1);
    u.line(1'b1, 2);
    rd_chk(OFS_DEVSTAT, 32'h0);
    chk(32'(de_n - d0), 32'h1);
    wr(OFS_CMD, 32'h20);
    u.line(1'b0, 8);
    rd_chk(OFS_DEVSTAT, 32'h08);
    u.line(1'b1, 2);
    rd_chk(OFS_DEVSTAT, 32'h0);
    chk(32'(as_n - a0 + de_n - d0), 32'h2);
    rd_chk(OFS_IRQ_STAT, 32'h30);
    wr(OFS_IRQ_CLR, 32'h30);
    wr(OFS_CMD, 32'h0);
    u.use_or <= 1'b1;
    u.line(1'b0, 2);
    wr(OFS_CMD, 32'h20);
    rd_chk(OFS_DEVSTAT, 32'h0);
    $display("legacy interrupt done");
  endtask : t_intx

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_cfg();
    t_err();
    t_np();
    t_intx();
    finish_test();
  end
endmodule : epsb_top_test

`default_nettype wire
